// File: design/pdi2c_defs.vh
`ifndef PDI2C_DEFS_VH
`define PDI2C_DEFS_VH

// --------------------------------------------------------------
// bus addresses
// --------------------------------------------------------------
`define PDI2C_EEPROM_ADDR 7'h50
`define PDI2C_HOST_ADDR_A 7'h20
`define PDI2C_HOST_ADDR_B 7'h24
`define PDI2C_SEC_ADDR 7'h30

// --------------------------------------------------------------
// framing
// --------------------------------------------------------------
`define PDI2C_BYTE_BITS 4'h8
`define PDI2C_RW_BIT 0

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define PDI2C_CLK_MHZ 250
`define PDI2C_SCL_KHZ 100
// quarter bit period of the controller port, in core cycles
`define PDI2C_QTR_CYC ((`PDI2C_CLK_MHZ * 1000) / (`PDI2C_SCL_KHZ * 4))
// stretch held after each received or sent byte, in core cycles
`define PDI2C_STRETCH_CYC 16'h0040
`define PDI2C_EE_BYTES 16'h0010

`endif

// File: design/pdi2c_target.v
`timescale 1ns/1ps
`include "pdi2c_defs.vh"

module pdi2c_target #(
	parameter STRETCH_CYC = 16
)
(
	input wire clk,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	input wire [6:0] addr_a,
	input wire [6:0] addr_b,
	input wire addr_b_en,
	input wire [7:0] tx_byte,
	output reg scl_oe_n,
	output reg sda_oe_n,
	output reg [7:0] rx_byte,
	output reg rx_valid,
	output reg tx_taken,
	output reg addr_hit,
	output reg addr_which,
	output reg busy
);

// --------------------------------------------------------------
// synchroniser and edge detect
// --------------------------------------------------------------
reg [1:0] scl_sync;
reg [1:0] sda_sync;
reg scl_d;
reg sda_d;
wire scl = scl_sync[1];
wire sda = sda_sync[1];
wire scl_rise = scl & ~scl_d;
wire scl_fall = ~scl & scl_d;
wire start_det = scl & scl_d & sda_d & ~sda;
wire stop_det = scl & scl_d & ~sda_d & sda;

localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_ACK = 3'd2;
localparam ST_RX = 3'd3;
localparam ST_TX = 3'd4;
localparam ST_MACK = 3'd5;
localparam ST_WAIT = 3'd6;

reg [2:0] state;
reg [7:0] shift;
reg [3:0] bitcnt;
reg reading;
reg [15:0] stretch;
reg ack_drive;

always @(posedge clk)
begin
	scl_sync <= {scl_sync[0], scl_in};
	sda_sync <= {sda_sync[0], sda_in};
	scl_d <= scl;
	sda_d <= sda;
end

// --------------------------------------------------------------
// protocol engine
// --------------------------------------------------------------
always @(posedge clk)
begin
	if (rst)
	begin
		state <= ST_IDLE;
		shift <= 8'h00;
		bitcnt <= 4'h0;
		reading <= 1'b0;
		stretch <= 16'h0000;
		ack_drive <= 1'b0;
		scl_oe_n <= 1'b1;
		sda_oe_n <= 1'b1;
		rx_byte <= 8'h00;
		rx_valid <= 1'b0;
		tx_taken <= 1'b0;
		addr_hit <= 1'b0;
		addr_which <= 1'b0;
		busy <= 1'b0;
	end
	else
	begin
		rx_valid <= 1'b0;
		tx_taken <= 1'b0;
		addr_hit <= 1'b0;
		if (stretch != 16'h0000)
			stretch <= stretch - 16'h0001;
		scl_oe_n <= ~(stretch != 16'h0000);
		if (stop_det)
		begin
			state <= ST_IDLE;
			sda_oe_n <= 1'b1;
			busy <= 1'b0;
			stretch <= 16'h0000;
		end
		else if (start_det)
		begin
			state <= ST_ADDR;
			bitcnt <= 4'h0;
			sda_oe_n <= 1'b1;
			busy <= 1'b1;
		end
		else
		begin
			case (state)
			ST_IDLE:
			begin
				sda_oe_n <= 1'b1;
			end
			ST_ADDR, ST_RX:
			begin
				if (scl_rise)
				begin
					shift <= {shift[6:0], sda};
					bitcnt <= bitcnt + 4'h1;
				end
				else if (scl_fall && bitcnt == `PDI2C_BYTE_BITS)
				begin
					bitcnt <= 4'h0;
					if (state == ST_ADDR)
					begin
						if (shift[7:1] == addr_a || (addr_b_en && shift[7:1] == addr_b))
						begin
							sda_oe_n <= 1'b0;
							reading <= shift[`PDI2C_RW_BIT];
							addr_hit <= 1'b1;
							addr_which <= (shift[7:1] != addr_a);
							state <= ST_ACK;
						end
						else
							state <= ST_WAIT;
					end
					else
					begin
						sda_oe_n <= 1'b0;
						rx_byte <= shift;
						rx_valid <= 1'b1;
						reading <= 1'b0;
						state <= ST_ACK;
					end
					stretch <= STRETCH_CYC[15:0];
				end
			end
			ST_ACK:
			begin
				// hold ack through high phase; on falling edge release SDA, or drive the first bit of a read
				if (scl_fall)
				begin
					if (reading)
					begin
						sda_oe_n <= tx_byte[7];
						shift <= {tx_byte[6:0], 1'b0};
						tx_taken <= 1'b1;
						bitcnt <= 4'h1;
						state <= ST_TX;
					end
					else
					begin
						sda_oe_n <= 1'b1;
						state <= ST_RX;
					end
				end
			end
			ST_TX:
			begin
				if (scl_fall)
				begin
					if (bitcnt == `PDI2C_BYTE_BITS)
					begin
						sda_oe_n <= 1'b1;
						bitcnt <= 4'h0;
						stretch <= STRETCH_CYC[15:0];
						state <= ST_MACK;
					end
					else
					begin
						sda_oe_n <= shift[7];
						shift <= {shift[6:0], 1'b0};
						bitcnt <= bitcnt + 4'h1;
					end
				end
			end
			ST_MACK:
			begin
				if (scl_rise)
					ack_drive <= ~sda;
				else if (scl_fall)
				begin
					if (ack_drive)
					begin
						sda_oe_n <= tx_byte[7];
						shift <= {tx_byte[6:0], 1'b0};
						tx_taken <= 1'b1;
						bitcnt <= 4'h1;
						state <= ST_TX;
					end
					else
						state <= ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				sda_oe_n <= 1'b1;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end
end

endmodule // pdi2c_target

// File: design/pdi2c_ports.v
`timescale 1ns/1ps
`include "pdi2c_defs.vh"

// Summary of operation
// - two independent target ports with interrupts
// - boot reads EEPROM at address 0x50
// - controller port assumes single controller
// - transfers begin only on idle bus
// - SDA fall, SCL high is start
// - matched address acknowledged low through high
// - one stable bit per clock pulse
// - SDA rise, SCL high is stop
// - bytes of eight bits plus acknowledge
// - transmitter releases SDA for acknowledge
// - receiver acknowledges; reader NACKs last byte
// - NACK ends read, target releases SDA
// - target may stretch SCL after bytes
// - target interrupts out, controller interrupt in
// - open-drain pins, inputs two-flop synchronised

module pdi2c_ports #(
	parameter STRETCH_CYC = 64,
	parameter QTR_CYC = `PDI2C_QTR_CYC,
	parameter EE_BYTES = 16
)
(
	input wire clk,
	input wire rst,
	input wire host_scl_in,
	input wire host_sda_in,
	output reg host_scl_oe_n,
	output reg host_sda_oe_n,
	output reg host_port_interrupt,
	input wire sec_scl_in,
	input wire sec_sda_in,
	output reg sec_scl_oe_n,
	output reg sec_sda_oe_n,
	output reg secondary_port_interrupt,
	input wire ctl_scl_in,
	input wire ctl_sda_in,
	output reg ctl_scl_oe_n,
	output reg ctl_sda_oe_n,
	input wire controller_port_interrupt_in,
	input wire [1:0] addr_index,
	input wire [7:0] host_tx_byte,
	input wire [7:0] sec_tx_byte,
	input wire host_irq_set,
	input wire sec_irq_set,
	input wire irq_clear,
	output reg [7:0] host_rx_byte,
	output reg host_rx_valid,
	output reg [7:0] sec_rx_byte,
	output reg sec_rx_valid,
	output reg [7:0] ee_byte,
	output reg ee_valid,
	output reg boot_done,
	output reg ee_found,
	output reg ctl_irq_level
);

// --------------------------------------------------------------
// input synchronisers (controller side and irq)
// --------------------------------------------------------------
reg [1:0] c_scl_s;
reg [1:0] c_sda_s;
reg [1:0] c_irq_s;
always @(posedge clk)
begin
	c_scl_s <= {c_scl_s[0], ctl_scl_in};
	c_sda_s <= {c_sda_s[0], ctl_sda_in};
	c_irq_s <= {c_irq_s[0], controller_port_interrupt_in};
end
wire c_scl = c_scl_s[1];
wire c_sda = c_sda_s[1];

// --------------------------------------------------------------
// target ports
// --------------------------------------------------------------
wire [6:0] host_a = `PDI2C_HOST_ADDR_A + {5'h00, addr_index};
wire [6:0] host_b = `PDI2C_HOST_ADDR_B + {5'h00, addr_index};
wire h_scl_oe_n, h_sda_oe_n, h_rx_valid, s_scl_oe_n, s_sda_oe_n, s_rx_valid;
wire [7:0] h_rx, s_rx;

pdi2c_target #(.STRETCH_CYC(STRETCH_CYC)) u_host (
	.clk(clk),
	.rst(rst),
	.scl_in(host_scl_in),
	.sda_in(host_sda_in),
	.addr_a(host_a),
	.addr_b(host_b),
	.addr_b_en(boot_done),
	.tx_byte(host_tx_byte),
	.scl_oe_n(h_scl_oe_n),
	.sda_oe_n(h_sda_oe_n),
	.rx_byte(h_rx),
	.rx_valid(h_rx_valid),
	.tx_taken(),
	.addr_hit(),
	.addr_which(),
	.busy()
);

pdi2c_target #(.STRETCH_CYC(STRETCH_CYC)) u_sec (
	.clk(clk),
	.rst(rst),
	.scl_in(sec_scl_in),
	.sda_in(sec_sda_in),
	.addr_a(`PDI2C_SEC_ADDR),
	.addr_b(`PDI2C_SEC_ADDR),
	.addr_b_en(1'b0),
	.tx_byte(sec_tx_byte),
	.scl_oe_n(s_scl_oe_n),
	.sda_oe_n(s_sda_oe_n),
	.rx_byte(s_rx),
	.rx_valid(s_rx_valid),
	.tx_taken(),
	.addr_hit(),
	.addr_which(),
	.busy()
);

// --------------------------------------------------------------
// output registers and interrupt pins
// --------------------------------------------------------------
always @(posedge clk)
begin
	if (rst)
	begin
		host_scl_oe_n <= 1'b1;
		host_sda_oe_n <= 1'b1;
		sec_scl_oe_n <= 1'b1;
		sec_sda_oe_n <= 1'b1;
		host_rx_byte <= 8'h00;
		host_rx_valid <= 1'b0;
		sec_rx_byte <= 8'h00;
		sec_rx_valid <= 1'b0;
		host_port_interrupt <= 1'b0;
		secondary_port_interrupt <= 1'b0;
		ctl_irq_level <= 1'b0;
	end
	else
	begin
		host_scl_oe_n <= h_scl_oe_n;
		host_sda_oe_n <= h_sda_oe_n;
		sec_scl_oe_n <= s_scl_oe_n;
		sec_sda_oe_n <= s_sda_oe_n;
		host_rx_valid <= h_rx_valid;
		sec_rx_valid <= s_rx_valid;
		if (h_rx_valid)
			host_rx_byte <= h_rx;
		if (s_rx_valid)
			sec_rx_byte <= s_rx;
		// set wins over clear
		if (host_irq_set)
			host_port_interrupt <= 1'b1;
		else if (irq_clear)
			host_port_interrupt <= 1'b0;
		if (sec_irq_set)
			secondary_port_interrupt <= 1'b1;
		else if (irq_clear)
			secondary_port_interrupt <= 1'b0;
		ctl_irq_level <= c_irq_s[1];
	end
end

// --------------------------------------------------------------
// controller port: boot read of the EEPROM
// --------------------------------------------------------------
localparam C_IDLE = 4'd0;
localparam C_START = 4'd1;
localparam C_BIT = 4'd2;
localparam C_ACK = 4'd3;
localparam C_RBIT = 4'd4;
localparam C_MACK = 4'd5;
localparam C_STOP = 4'd6;
localparam C_DONE = 4'd7;

reg [3:0] cstate;
reg [1:0] phase;
reg [15:0] qcnt;
reg [3:0] cbit;
reg [7:0] cshift;
reg [15:0] nbytes;
reg [1:0] hold_idle;

wire tick = (qcnt == 16'h0000);
// stretch wait: SCL released but still seen low
wire held = ctl_scl_oe_n & ~c_scl;
// the sampling quarter does not advance during a stretch
wire adv = tick & ~(held & (phase == 2'd2));

always @(posedge clk)
begin
	if (rst)
	begin
		cstate <= C_IDLE;
		phase <= 2'd0;
		qcnt <= 16'h0000;
		cbit <= 4'h0;
		cshift <= 8'h00;
		nbytes <= 16'h0000;
		hold_idle <= 2'd0;
		ctl_scl_oe_n <= 1'b1;
		ctl_sda_oe_n <= 1'b1;
		ee_byte <= 8'h00;
		ee_valid <= 1'b0;
		boot_done <= 1'b0;
		ee_found <= 1'b0;
	end
	else
	begin
		ee_valid <= 1'b0;
		if (!tick)
			qcnt <= qcnt - 16'h0001;
		else if (adv)
		begin
			// restart the quarter timer; in phase 2 only once SCL is seen high
			qcnt <= QTR_CYC[15:0];
			phase <= phase + 2'd1;
		end
		case (cstate)
		C_IDLE:
		begin
			// wait for both lines idle high
			if (c_scl && c_sda)
				hold_idle <= (hold_idle == 2'd3) ? hold_idle : hold_idle + 2'd1;
			else
				hold_idle <= 2'd0;
			if (hold_idle == 2'd3 && adv && phase == 2'd1)
			begin
				ctl_sda_oe_n <= 1'b0; // start while SCL high
				cshift <= {`PDI2C_EEPROM_ADDR, 1'b1};
				cbit <= 4'h0;
				cstate <= C_START;
			end
		end
		C_START:
		begin
			if (adv && phase == 2'd3)
			begin
				ctl_scl_oe_n <= 1'b0;
				cstate <= C_BIT;
			end
		end
		C_BIT, C_RBIT:
		begin
			if (adv && phase == 2'd0)
			begin
				// data changes a quarter after SCL falls
				ctl_sda_oe_n <= (cstate == C_BIT) ? cshift[7] : 1'b1;
				if (cstate == C_BIT)
					cshift <= {cshift[6:0], 1'b0};
			end
			else if (adv && phase == 2'd1)
				ctl_scl_oe_n <= 1'b1;
			else if (adv && phase == 2'd2)
			begin
				if (cstate == C_RBIT)
					cshift <= {cshift[6:0], c_sda};
				cbit <= cbit + 4'h1;
			end
			else if (adv && phase == 2'd3)
			begin
				ctl_scl_oe_n <= 1'b0;
				if (cbit == `PDI2C_BYTE_BITS)
				begin
					if (cstate == C_RBIT)
					begin
						ee_byte <= cshift;
						ee_valid <= 1'b1;
						nbytes <= nbytes + 16'h0001;
					end
					cbit <= 4'h0;
					cstate <= (cstate == C_RBIT) ? C_MACK : C_ACK;
				end
			end
		end
		C_ACK, C_MACK:
		begin
			if (adv && phase == 2'd0)
			begin
				// release for the target ack; nack the last byte
				ctl_sda_oe_n <= (cstate == C_MACK) ? (nbytes == EE_BYTES[15:0]) : 1'b1;
			end
			else if (adv && phase == 2'd1)
				ctl_scl_oe_n <= 1'b1;
			else if (adv && phase == 2'd2 && cstate == C_ACK)
				ee_found <= ~c_sda;
			else if (adv && phase == 2'd3)
			begin
				ctl_scl_oe_n <= 1'b0;
				if ((cstate == C_ACK && !ee_found) || nbytes == EE_BYTES[15:0])
					cstate <= C_STOP;
				else
					cstate <= C_RBIT;
			end
		end
		C_STOP:
		begin
			if (adv && phase == 2'd0)
				ctl_sda_oe_n <= 1'b0;
			else if (adv && phase == 2'd1)
				ctl_scl_oe_n <= 1'b1;
			else if (adv && phase == 2'd3)
			begin
				ctl_sda_oe_n <= 1'b1; // stop while SCL high
				cstate <= C_DONE;
			end
		end
		C_DONE:
		begin
			boot_done <= 1'b1; // no arbitration: single controller only
		end
		default:
			cstate <= C_IDLE;
		endcase
	end
end

endmodule // pdi2c_ports

// File: sim/pdi2c_ports_sva.sv
`timescale 1ns/1ps
module pdi2c_ports_sva #(
	parameter STRETCH_CYC = 64,
	parameter QTR_CYC = 625,
	parameter EE_BYTES = 16
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic host_scl_in,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic host_port_interrupt,
	input wire logic sec_scl_in,
	input wire logic sec_sda_oe_n,
	input wire logic secondary_port_interrupt,
	input wire logic controller_port_interrupt_in,
	input wire logic ctl_irq_level,
	input wire logic host_irq_set,
	input wire logic sec_irq_set,
	input wire logic irq_clear,
	input wire logic host_rx_valid,
	input wire logic sec_rx_valid,
	input wire logic boot_done
);
	logic [15:0] low_cnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----
	// length of the current clock stretch
	// ----
	always @(posedge clk)
	begin
		if (rst || host_scl_oe_n)
			low_cnt <= 16'h0000;
		else
			low_cnt <= low_cnt + 16'h0001;
	end
	reset_release_a: assert property (disable iff (1'b0)
		rst |=> host_scl_oe_n && host_sda_oe_n && sec_sda_oe_n && !boot_done)
		else $error("pins or boot flag active after reset");
	host_irq_set_a: assert property (host_irq_set |=> host_port_interrupt)
		else $error("host interrupt not raised");
	irq_clear_a: assert property (irq_clear && !host_irq_set && !sec_irq_set
		|=> !host_port_interrupt && !secondary_port_interrupt)
		else $error("interrupt not cleared");
	sec_irq_set_a: assert property (sec_irq_set |=> secondary_port_interrupt)
		else $error("secondary interrupt not raised");
	ctl_irq_sync_a: assert property (
		(!rst && controller_port_interrupt_in) [*6] |-> ctl_irq_level)
		else $error("controller interrupt input not seen");
	stretch_len_a: assert property (
		$rose(host_scl_oe_n) && !$past(rst) |-> low_cnt >= STRETCH_CYC)
		else $error("clock stretch too short");
	stretch_end_a: assert property (!host_scl_oe_n |-> low_cnt < STRETCH_CYC + 4)
		else $error("clock stretch never released");
	host_sda_low_a: assert property ($changed(host_sda_oe_n) |-> !host_scl_in)
		else $error("host data changed while clock high");
	sec_sda_low_a: assert property ($changed(sec_sda_oe_n) |-> !sec_scl_in)
		else $error("secondary data changed while clock high");
	host_write_c: cover property (host_rx_valid);
	sec_write_c: cover property (sec_rx_valid);
	boot_end_c: cover property ($rose(boot_done));
endmodule // pdi2c_ports_sva

bind pdi2c_ports pdi2c_ports_sva #(.STRETCH_CYC(STRETCH_CYC), .QTR_CYC(QTR_CYC),
	.EE_BYTES(EE_BYTES)) chk_u (.clk(clk), .rst(rst), .host_scl_in(host_scl_in),
	.host_scl_oe_n(host_scl_oe_n), .host_sda_oe_n(host_sda_oe_n),
	.host_port_interrupt(host_port_interrupt), .sec_scl_in(sec_scl_in),
	.sec_sda_oe_n(sec_sda_oe_n), .secondary_port_interrupt(secondary_port_interrupt),
	.controller_port_interrupt_in(controller_port_interrupt_in),
	.ctl_irq_level(ctl_irq_level), .host_irq_set(host_irq_set), .sec_irq_set(sec_irq_set),
	.irq_clear(irq_clear), .host_rx_valid(host_rx_valid), .sec_rx_valid(sec_rx_valid),
	.boot_done(boot_done));

// File: sim/pdi2c_host_model.sv
`timescale 1ns/1ps
module pdi2c_host_model
(
	input wire logic clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_n,
	output logic sda_oe_n
);
	initial
	begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	task hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task start;
		hold(6);
		sda_oe_n <= 1'b0;
		hold(6);
		scl_oe_n <= 1'b0;
		hold(3);
	endtask
	// one 52 ns clock pulse, data set mid-low
	task xbit(input logic b, output logic r);
		sda_oe_n <= b;
		hold(3);
		scl_oe_n <= 1'b1;
		hold(1);
		repeat (400) if (!scl_in) @(posedge clk);
		hold(3);
		r = sda_in;
		hold(3);
		scl_oe_n <= 1'b0;
		hold(3);
	endtask
	task byte_x(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r[i]);
		xbit(a, ack);
	endtask
	task stop;
		sda_oe_n <= 1'b0;
		hold(3);
		scl_oe_n <= 1'b1;
		hold(1);
		repeat (400) if (!scl_in) @(posedge clk);
		hold(5);
		sda_oe_n <= 1'b1;
		hold(6);
	endtask
endmodule // pdi2c_host_model

// File: sim/pdi2c_ports_test.sv
`timescale 1ns/1ps
module pdi2c_ports_test;
	logic clk, rst, host_irq_set, sec_irq_set, irq_clear, ctl_int, ack;
	logic [7:0] host_tx, host_got, sec_got, ctl_addr, r;
	int ctl_bits, mismatches, cmp_count;
	wire h_scl_oe_n, h_sda_oe_n, s_scl_oe_n, s_sda_oe_n, c_scl_oe_n, c_sda_oe_n;
	wire mh_scl, mh_sda, ms_scl, ms_sda, host_int, sec_int, ctl_lvl, host_rv, sec_rv;
	wire boot_done, ee_found;
	wire [7:0] host_rb, sec_rb;
	// open-drain lines with pull-ups; no eeprom fitted
	wire host_scl = h_scl_oe_n & mh_scl;
	wire host_sda = h_sda_oe_n & mh_sda;
	wire sec_scl = s_scl_oe_n & ms_scl;
	wire sec_sda = s_sda_oe_n & ms_sda;
	wire ctl_scl = c_scl_oe_n;
	wire ctl_sda = c_sda_oe_n;
	pdi2c_ports #(.STRETCH_CYC(8), .QTR_CYC(4), .EE_BYTES(2)) dut_u (.clk(clk), .rst(rst),
		.host_scl_in(host_scl), .host_sda_in(host_sda), .host_scl_oe_n(h_scl_oe_n),
		.host_sda_oe_n(h_sda_oe_n), .host_port_interrupt(host_int), .sec_scl_in(sec_scl),
		.sec_sda_in(sec_sda), .sec_scl_oe_n(s_scl_oe_n), .sec_sda_oe_n(s_sda_oe_n),
		.secondary_port_interrupt(sec_int), .ctl_scl_in(ctl_scl), .ctl_sda_in(ctl_sda),
		.ctl_scl_oe_n(c_scl_oe_n), .ctl_sda_oe_n(c_sda_oe_n),
		.controller_port_interrupt_in(ctl_int), .addr_index(2'h0), .host_tx_byte(host_tx),
		.sec_tx_byte(8'h00), .host_irq_set(host_irq_set), .sec_irq_set(sec_irq_set),
		.irq_clear(irq_clear), .host_rx_byte(host_rb), .host_rx_valid(host_rv),
		.sec_rx_byte(sec_rb), .sec_rx_valid(sec_rv), .ee_byte(), .ee_valid(),
		.boot_done(boot_done), .ee_found(ee_found), .ctl_irq_level(ctl_lvl));
	pdi2c_host_model mh (.clk(clk), .scl_in(host_scl), .sda_in(host_sda),
		.scl_oe_n(mh_scl), .sda_oe_n(mh_sda));
	pdi2c_host_model ms (.clk(clk), .scl_in(sec_scl), .sda_in(sec_sda),
		.scl_oe_n(ms_scl), .sda_oe_n(ms_sda));
	// ----
	// capture of received bytes and boot address
	// ----
	always @(posedge clk)
	begin
		if (host_rv)
			host_got <= host_rb;
		if (sec_rv)
			sec_got <= sec_rb;
	end
	always @(negedge ctl_sda)
		if (ctl_scl)
			ctl_bits = 0;
	always @(posedge ctl_scl)
		if (ctl_bits < 8)
		begin
			ctl_addr = {ctl_addr[6:0], ctl_sda};
			ctl_bits++;
		end
	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task t_early;
		check("boot pending", 8'h00, boot_done);
		mh.start();
		mh.byte_x({7'h24, 1'b0}, 1'b1, r, ack);
		check("early port b", 8'h01, ack);
		mh.stop();
	endtask
	task t_write;
		mh.start();
		mh.byte_x({7'h20, 1'b0}, 1'b1, r, ack);
		check("addr ack", 8'h00, ack);
		mh.byte_x(8'hA5, 1'b1, r, ack);
		mh.byte_x(8'h3C, 1'b1, r, ack);
		check("data ack", 8'h00, ack);
		mh.stop();
		check("host rx", 8'h3C, host_got);
	endtask
	task t_nomatch;
		mh.start();
		mh.byte_x({7'h31, 1'b0}, 1'b1, r, ack);
		check("bad addr ack", 8'h01, ack);
		mh.byte_x(8'h77, 1'b1, r, ack);
		mh.stop();
		check("ignored rx", 8'h3C, host_got);
	endtask
	task t_read;
		host_tx <= 8'h96;
		mh.start();
		mh.byte_x({7'h20, 1'b1}, 1'b1, r, ack);
		mh.byte_x(8'hFF, 1'b0, r, ack);
		check("read 1", 8'h96, r);
		mh.byte_x(8'hFF, 1'b1, r, ack);
		check("read 2", 8'h96, r);
		mh.stop();
		check("sda free", 8'h01, h_sda_oe_n);
	endtask
	task t_boot;
		for (int i = 0; i < 3000 && boot_done !== 1'b1; i++)
			@(posedge clk);
		check("boot done", 8'h01, boot_done);
		check("eeprom addr", 8'hA1, ctl_addr);
		check("no eeprom", 8'h00, ee_found);
		mh.start();
		mh.byte_x({7'h24, 1'b0}, 1'b1, r, ack);
		mh.stop();
		check("port b ack", 8'h00, ack);
	endtask
	task t_sec;
		ms.start();
		ms.byte_x({7'h30, 1'b0}, 1'b1, r, ack);
		check("sec ack", 8'h00, ack);
		ms.byte_x(8'h5A, 1'b1, r, ack);
		ms.stop();
		check("sec rx", 8'h5A, sec_got);
	endtask
	task t_irq;
		host_irq_set <= 1'b1;
		irq_clear <= 1'b1;
		ctl_int <= 1'b1;
		@(posedge clk);
		host_irq_set <= 1'b0;
		sec_irq_set <= 1'b1;
		@(posedge clk);
		sec_irq_set <= 1'b0;
		irq_clear <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check("host irq", 8'h00, host_int);
		check("sec irq", 8'h01, sec_int);
		check("ctl irq", 8'h01, ctl_lvl);
		@(posedge clk);
		irq_clear <= 1'b1;
		@(posedge clk);
		irq_clear <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("sec irq clear", 8'h00, sec_int);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("watchdog expired");
		results();
	end
	initial
	begin
		rst = 1'b1;
		host_irq_set = 1'b0;
		sec_irq_set = 1'b0;
		irq_clear = 1'b0;
		ctl_int = 1'b0;
		host_tx = 8'h00;
		ctl_bits = 8;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_early();
		t_write();
		t_nomatch();
		t_read();
		t_sec();
		t_boot();
		t_irq();
		results();
	end
endmodule // pdi2c_ports_test
